// File: tppc_top.sv
// timer channel: interval, pulse generator and pulse width capture
//
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
module tppc_top #(
	parameter int COUNT_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [COUNT_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [COUNT_W-1:0] rd_data,
	input wire logic primary_capture_input,
	input wire logic secondary_capture_input,
	output logic timer_output_pin,
	output logic period_match_irq,
	output logic width_match_irq,
	output logic overflow_flag
);
	// control fields are eight bits wide and must fit the data port
	if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
		$error("tppc_top: COUNT_W must lie between 8 and 32");
	end

	localparam logic [COUNT_W-1:0] ALL_ONES = '1;
	localparam logic [COUNT_W-1:0] ONE = COUNT_W'(1);

	logic [COUNT_W-1:0] count_reg, count_next;
	logic [COUNT_W-1:0] period_reg, period_next;
	logic [COUNT_W-1:0] width_reg, width_next;
	tppc_pkg::tppc_mode_type mode_reg, mode_next;
	tppc_pkg::tppc_ccc_type ccc_reg, ccc_next;
	tppc_pkg::tppc_pes_type pes_reg, pes_next;
	tppc_pkg::tppc_outc_type outc_reg, outc_next;
	logic ovf_reg, ovf_next;
	logic out_level_reg, out_level_next;
	logic pin_reg, pin_next;
	logic pm_irq_reg, pm_irq_next;
	logic wm_irq_reg, wm_irq_next;
	logic [COUNT_W-1:0] rd_data_reg, rd_data_next;
	logic [tppc_pkg::PRESCALE_W-1:0] presc_reg, presc_next;
	logic tick;
	logic running;
	logic primary_edge;
	logic secondary_edge;

	// equality against a compare register, used for both match paths
	function automatic logic hits(input logic [COUNT_W-1:0] a, input logic [COUNT_W-1:0] b);
		hits = (a == b);
	endfunction

	// count clock: the prescaler runs always so the input filters keep tracking
	// the pins while stopped, and a restart does not see a stale edge
	always_comb begin
		presc_next = presc_reg + tppc_pkg::PRESCALE_W'(1);
		case (pes_reg.clk_sel)
			tppc_pkg::CLK_DIV1: tick = 1'b1;
			tppc_pkg::CLK_DIV4: tick = (presc_reg[1:0] == tppc_pkg::DIV_SEL1_LAST[1:0]);
			tppc_pkg::CLK_DIV256: tick = (presc_reg == tppc_pkg::DIV_SEL2_LAST);
			default: tick = 1'b0; // external event clock is not offered here
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_next;
		end
	end

	assign running = (mode_reg != tppc_pkg::MODE_STOP);

	tppc_edge_filter u_primary (
		.clock(clock),
		.rst(rst),
		.sample_tick(tick),
		.pin_in(primary_capture_input),
		.edge_sel(pes_reg.primary_edge),
		.edge_pulse(primary_edge)
	);

	tppc_edge_filter u_secondary (
		.clock(clock),
		.rst(rst),
		.sample_tick(tick),
		.pin_in(secondary_capture_input),
		.edge_sel(pes_reg.secondary_edge),
		.edge_pulse(secondary_edge)
	);

	// register writes first, then counting, matching and captures override
	always_comb begin
		count_next = count_reg;
		period_next = period_reg;
		width_next = width_reg;
		mode_next = mode_reg;
		ccc_next = ccc_reg;
		pes_next = pes_reg;
		outc_next = outc_reg;
		ovf_next = ovf_reg;
		out_level_next = out_level_reg;
		pm_irq_next = 1'b0;
		wm_irq_next = 1'b0;
		rd_data_next = '0;

		if (wr_en) begin
			if (addr == tppc_pkg::ADDR_PERIOD) begin
				period_next = wr_data; // relies on the timer being stopped
			end else if (addr == tppc_pkg::ADDR_WIDTH) begin
				width_next = wr_data;
			end else if (addr == tppc_pkg::ADDR_MODE) begin
				mode_next = tppc_pkg::tppc_mode_type'(wr_data[1:0]);
				if (!running) begin
					// a start clears the counter and loads the pin's start level
					count_next = '0;
					out_level_next = outc_reg.start_level;
				end
			end else if (addr == tppc_pkg::ADDR_CCC) begin
				ccc_next = wr_data[7:0];
			end else if (addr == tppc_pkg::ADDR_PES) begin
				pes_next = wr_data[7:0];
			end else if (addr == tppc_pkg::ADDR_OUTC) begin
				outc_next = wr_data[7:0];
			end else if (addr == tppc_pkg::ADDR_STATUS) begin
				if (wr_data[tppc_pkg::STATUS_OVF_BIT]) begin
					ovf_next = 1'b0; // software clears the flag after reading
				end
			end
		end

		if (running && tick) begin
			count_next = count_reg + ONE;
			case (mode_reg)
				tppc_pkg::MODE_CLEAR_MATCH: begin
					if (hits(count_reg, period_reg)) begin
						count_next = '0;
						pm_irq_next = 1'b1;
						if (outc_reg.invert_on_period_match) begin
							out_level_next = ~out_level_next; // period N+1 clocks
						end
						if (period_reg == ALL_ONES) begin
							ovf_next = 1'b1;
						end
					end
					if (!ccc_reg.width_is_capture && hits(count_reg, width_reg)) begin
						wm_irq_next = 1'b1;
						if (outc_reg.invert_on_width_match) begin
							out_level_next = ~out_level_next; // high M+1 clocks
						end
					end
				end
				default: begin
					// free-running and restart both wrap through zero
					if (count_reg == ALL_ONES) begin
						ovf_next = 1'b1;
					end
				end
			endcase
		end

		if (running && primary_edge && mode_reg != tppc_pkg::MODE_CLEAR_MATCH) begin
			if (ccc_reg.width_is_capture) begin
				width_next = count_reg;
				wm_irq_next = 1'b1;
			end
			if (mode_reg == tppc_pkg::MODE_RESTART) begin
				count_next = '0; // restart in step with the primary edge
			end
		end

		if (running && secondary_edge && ccc_reg.period_is_capture) begin
			if (mode_reg != tppc_pkg::MODE_CLEAR_MATCH) begin
				period_next = count_reg;
				pm_irq_next = 1'b1;
			end
		end

		pin_next = out_level_next & outc_next.output_enable;

		if (rd_en) begin
			if (addr == tppc_pkg::ADDR_COUNT) begin
				rd_data_next = count_reg;
			end else if (addr == tppc_pkg::ADDR_PERIOD) begin
				rd_data_next = period_reg;
			end else if (addr == tppc_pkg::ADDR_WIDTH) begin
				rd_data_next = width_reg;
			end else if (addr == tppc_pkg::ADDR_MODE) begin
				rd_data_next = COUNT_W'(mode_reg);
			end else if (addr == tppc_pkg::ADDR_CCC) begin
				rd_data_next = COUNT_W'(ccc_reg);
			end else if (addr == tppc_pkg::ADDR_PES) begin
				rd_data_next = COUNT_W'(pes_reg);
			end else if (addr == tppc_pkg::ADDR_OUTC) begin
				rd_data_next = COUNT_W'(outc_reg);
			end else begin
				rd_data_next = COUNT_W'(ovf_reg);
			end
		end
	end

	// channel state apart from the prescaler; read data stands only in the cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
			period_reg <= '0;
			width_reg <= '0;
			mode_reg <= tppc_pkg::MODE_STOP;
			ccc_reg <= tppc_pkg::CTRL_RESET;
			pes_reg <= tppc_pkg::CTRL_RESET;
			outc_reg <= tppc_pkg::CTRL_RESET;
			ovf_reg <= 1'b0;
			out_level_reg <= 1'b0;
			pin_reg <= 1'b0;
			pm_irq_reg <= 1'b0;
			wm_irq_reg <= 1'b0;
			rd_data_reg <= '0;
		end else begin
			count_reg <= count_next;
			period_reg <= period_next;
			width_reg <= width_next;
			mode_reg <= mode_next;
			ccc_reg <= ccc_next;
			pes_reg <= pes_next;
			outc_reg <= outc_next;
			ovf_reg <= ovf_next;
			out_level_reg <= out_level_next;
			pin_reg <= pin_next;
			pm_irq_reg <= pm_irq_next;
			wm_irq_reg <= wm_irq_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign timer_output_pin = pin_reg;
	assign period_match_irq = pm_irq_reg;
	assign width_match_irq = wm_irq_reg;
	assign overflow_flag = ovf_reg;
endmodule
`default_nettype wire

// File: tppc_pkg.sv
// shared constants and types for the pulse timer and capture channel
`default_nettype none
package tppc_pkg;
	// register word addresses on the plain register port
	localparam logic [2:0] ADDR_COUNT = 3'h0;
	localparam logic [2:0] ADDR_PERIOD = 3'h1;
	localparam logic [2:0] ADDR_WIDTH = 3'h2;
	localparam logic [2:0] ADDR_MODE = 3'h3;
	localparam logic [2:0] ADDR_CCC = 3'h4;
	localparam logic [2:0] ADDR_PES = 3'h5;
	localparam logic [2:0] ADDR_OUTC = 3'h6;
	localparam logic [2:0] ADDR_STATUS = 3'h7;

	// status register field positions
	localparam int STATUS_OVF_BIT = 0;

	// reset values of the control registers
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// prescaler divide ratios for count clock selections one and two
	localparam int PRESCALE_W = 8;
	localparam logic [7:0] DIV_SEL1_LAST = 8'h03;
	localparam logic [7:0] DIV_SEL2_LAST = 8'hff;

	typedef enum logic [1:0] {
		MODE_STOP = 2'b00,
		MODE_RESTART = 2'b01,
		MODE_FREE = 2'b10,
		MODE_CLEAR_MATCH = 2'b11
	} tppc_mode_type;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_PROHIBITED = 2'b10,
		EDGE_BOTH = 2'b11
	} tppc_edge_type;

	typedef enum logic [1:0] {
		CLK_DIV1 = 2'b00,
		CLK_DIV4 = 2'b01,
		CLK_DIV256 = 2'b10,
		CLK_NONE = 2'b11
	} tppc_clk_sel_type;

	// prescale_edge_select layout
	typedef struct packed {
		logic [1:0] secondary_edge;
		logic [1:0] primary_edge;
		logic [1:0] spare;
		logic [1:0] clk_sel;
	} tppc_pes_type;

	// output_control layout
	typedef struct packed {
		logic [2:0] spare_hi;
		logic invert_on_width_match;
		logic spare_lo;
		logic start_level;
		logic invert_on_period_match;
		logic output_enable;
	} tppc_outc_type;

	// capture_compare_control layout
	typedef struct packed {
		logic [4:0] spare_hi;
		logic width_is_capture;
		logic spare_lo;
		logic period_is_capture;
	} tppc_ccc_type;
endpackage
`default_nettype wire

// File: tppc_edge_filter.sv
// glitch filter and edge detector for one capture input
`default_nettype none
module tppc_edge_filter (
	input wire logic clock,
	input wire logic rst,
	input wire logic sample_tick,
	input wire logic pin_in,
	input wire logic [1:0] edge_sel,
	output logic edge_pulse
);
	logic sample_reg, sample_next;
	logic level_reg, level_next;
	logic edge_reg, edge_next;

	// a level is accepted only after two equal samples taken on the count clock
	always_comb begin
		sample_next = sample_reg;
		level_next = level_reg;
		edge_next = 1'b0;
		if (sample_tick) begin
			sample_next = pin_in;
			if (pin_in == sample_reg && sample_reg != level_reg) begin
				level_next = sample_reg;
				case (edge_sel)
					tppc_pkg::EDGE_FALL: edge_next = ~sample_reg;
					tppc_pkg::EDGE_RISE: edge_next = sample_reg;
					tppc_pkg::EDGE_BOTH: edge_next = 1'b1;
					default: edge_next = 1'b0; // prohibited code never fires
				endcase
			end
		end
	end

	// level resets low, so a pin held high at reset shows as a rising edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sample_reg <= 1'b0;
			level_reg <= 1'b0;
			edge_reg <= 1'b0;
		end else begin
			sample_reg <= sample_next;
			level_reg <= level_next;
			edge_reg <= edge_next;
		end
	end

	assign edge_pulse = edge_reg;
endmodule
`default_nettype wire

// File: tppc_checker_assertions.sv
// assertion checker for the pulse timer and capture channel
`default_nettype none
module tppc_checker #(
	parameter int COUNT_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [COUNT_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [COUNT_W-1:0] rd_data,
	input wire logic primary_capture_input,
	input wire logic secondary_capture_input,
	input wire logic timer_output_pin,
	input wire logic period_match_irq,
	input wire logic width_match_irq,
	input wire logic overflow_flag
);
	logic [1:0] mode_reg;
	logic [COUNT_W-1:0] per_reg;
	logic [COUNT_W-1:0] wid_reg;
	logic [7:0] pes_reg;
	logic [7:0] outc_reg;
	logic [COUNT_W:0] gap_reg;
	logic [COUNT_W:0] hi_reg;
	logic [3:0] age_reg;
	logic prev_reg;
	logic seen_reg;
	logic programmable_pulse_output;
	logic cap;
	logic mode_wr;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// cycle-exact checks only hold at one count per clock
	assign mode_wr = wr_en && addr == tppc_pkg::ADDR_MODE;
	assign programmable_pulse_output = mode_reg == 2'h3 && pes_reg[1:0] == 2'h0 && outc_reg == 8'h17;
	assign cap = mode_reg == 2'h2 && pes_reg[1:0] == 2'h0;
	// shadow control writes; run lengths since the last event
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_reg <= 2'h0;
			per_reg <= '0;
			wid_reg <= '0;
			pes_reg <= 8'h00;
			outc_reg <= 8'h00;
			gap_reg <= '0;
			hi_reg <= '0;
			age_reg <= 4'h0;
			prev_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			if (mode_wr) mode_reg <= wr_data[1:0];
			if (wr_en && addr == tppc_pkg::ADDR_PERIOD) per_reg <= wr_data;
			if (wr_en && addr == tppc_pkg::ADDR_WIDTH) wid_reg <= wr_data;
			if (wr_en && addr == tppc_pkg::ADDR_PES) pes_reg <= wr_data[7:0];
			if (wr_en && addr == tppc_pkg::ADDR_OUTC) outc_reg <= wr_data[7:0];
			gap_reg <= period_match_irq ? 1'h1 : gap_reg + 1'h1;
			hi_reg <= timer_output_pin ? hi_reg + 1'h1 : '0;
			age_reg <= primary_capture_input != prev_reg ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
			prev_reg <= primary_capture_input;
			// the first period after a start has no reference point
			seen_reg <= mode_wr ? 1'b0 : seen_reg | period_match_irq;
		end
	end
	rd_quiet_a:
	assert property (!$past(rd_en) |-> rd_data == '0) else $error("stray read data");
	ovf_sticky_a:
	assert property (overflow_flag && !(wr_en && addr == tppc_pkg::ADDR_STATUS && wr_data[0])
		|=> overflow_flag) else $error("overflow flag dropped by itself");
	ovf_full_a:
	assert property ($rose(overflow_flag) && mode_reg == 2'h3 |-> &per_reg)
		else $error("overflow with a short period");
	pin_off_a:
	assert property ((!outc_reg[0]) [*2] |-> !timer_output_pin) else $error("pin driven while off");
	high_time_a:
	assert property ($fell(timer_output_pin) && programmable_pulse_output |-> hi_reg == wid_reg + 1'h1)
		else $error("pulse high time wrong");
	period_gap_a:
	assert property (period_match_irq && programmable_pulse_output && seen_reg |-> gap_reg == per_reg + 1'h1)
		else $error("period request spacing wrong");
	width_gap_a:
	assert property (width_match_irq && programmable_pulse_output && seen_reg |-> gap_reg == wid_reg + 1'h1)
		else $error("width request out of place");
	cap_delay_a:
	assert property (width_match_irq && cap |-> age_reg >= 4'h2 && age_reg <= 4'h7)
		else $error("capture request without a filtered edge");
	cover property (programmable_pulse_output && seen_reg && period_match_irq);
	cover property (cap && width_match_irq);
	cover property ($rose(overflow_flag));
endmodule
bind tppc_top tppc_checker #(.COUNT_W(COUNT_W)) tppc_checker_i (.clock, .rst, .addr, .wr_data,
	.wr_en, .rd_en, .rd_data, .primary_capture_input, .secondary_capture_input,
	.timer_output_pin, .period_match_irq, .width_match_irq, .overflow_flag);
`default_nettype wire

// File: tppc_pin_src.sv
// far-side model: pulse sources on the two capture pins
`default_nettype none
module tppc_pin_src (
	input wire logic clock,
	input wire logic a_lvl,
	input wire logic b_lvl,
	output logic pa,
	output logic pb
);
	timeunit 1ns;
	timeprecision 1ns;
	// both pins are pure inputs of the channel; never driven by it
	always_ff @(posedge clock) begin
		pa <= a_lvl;
		pb <= b_lvl;
	end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the pulse timer and capture channel
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic a_lvl = 1'b0;
	logic b_lvl = 1'b0;
	logic last;
	logic [2:0] addr = 3'h0;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] rd_data, v, w, c, t, p;
	logic pa, pb, pin, pirq, wirq, ovf;
	int error_cnt = 0;
	int n_compared = 0;
	always #50 clock = ~clock;
	tppc_pin_src tppc_pin_src_i (.clock(clock), .a_lvl(a_lvl), .b_lvl(b_lvl), .pa(pa), .pb(pb));
	tppc_top tppc_top_i (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .primary_capture_input(pa),
		.secondary_capture_input(pb), .timer_output_pin(pin), .period_match_irq(pirq),
		.width_match_irq(wirq), .overflow_flag(ovf));
	task chk(input string s, input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe, so sample just then
	task rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	task cnt(input int n);
		repeat (n) begin
			@(posedge clock);
			#1 c += {15'h0000, wirq};
		end
	endtask
	// three whole periods, so the phase of the window does not matter
	task scan;
		#1 last = pin;
		c = 16'h0000;
		t = 16'h0000;
		p = 16'h0000;
		w = 16'h0000;
		repeat (18) begin
			@(posedge clock);
			#1 c += {15'h0000, pin};
			t += {15'h0000, pin ^ last};
			p += {15'h0000, pirq};
			w += {15'h0000, wirq};
			last = pin;
		end
	endtask
	task t_ppg;
		wr(tppc_pkg::ADDR_CCC, 16'h0000);
		wr(tppc_pkg::ADDR_PERIOD, 16'h0005);
		wr(tppc_pkg::ADDR_WIDTH, 16'h0002);
		wr(tppc_pkg::ADDR_OUTC, 16'hff17);
		wr(tppc_pkg::ADDR_PES, 16'h0000);
		wr(tppc_pkg::ADDR_MODE, 16'h0003);
		repeat (20) @(posedge clock);
		scan();
		chk("high cycles", c, 16'h0009);
		chk("toggles", t, 16'h0006);
		chk("period requests", p, 16'h0003);
		chk("width requests", w, 16'h0003);
		rd(tppc_pkg::ADDR_COUNT, v);
		chk("count bound", {15'h0000, v <= 16'h0005}, 16'h0001);
		rd(tppc_pkg::ADDR_OUTC, v);
		chk("output control", v, 16'h0017);
		chk("no overflow", {15'h0000, ovf}, 16'h0000);
		// wait for a width request, so the rewrite lands after this period's width match
		for (int i = 0; i < 8 && wirq !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		// no interrupt mask lives in this block, so only the pin side of the sequence applies
		wr(tppc_pkg::ADDR_OUTC, 16'h0007);
		wr(tppc_pkg::ADDR_WIDTH, 16'h0004);
		@(posedge clock); // one count clock before inversion is re-armed
		wr(tppc_pkg::ADDR_OUTC, 16'h0017);
		repeat (6) @(posedge clock);
		scan();
		chk("new high cycles", c, 16'h000f);
		chk("new toggles", t, 16'h0006);
		chk("new width requests", w, 16'h0003);
		wr(tppc_pkg::ADDR_MODE, 16'h0000);
		wr(tppc_pkg::ADDR_OUTC, 16'h0000);
	endtask
	task t_ovf;
		wr(tppc_pkg::ADDR_PERIOD, 16'hffff);
		wr(tppc_pkg::ADDR_MODE, 16'h0003);
		for (int i = 0; i < 66000 && ovf !== 1'b1; i++) @(posedge clock);
		wr(tppc_pkg::ADDR_MODE, 16'h0000);
		repeat (4) @(posedge clock);
		rd(tppc_pkg::ADDR_STATUS, v);
		chk("overflow kept", v, 16'h0001);
		wr(tppc_pkg::ADDR_STATUS, 16'h0001);
		rd(tppc_pkg::ADDR_STATUS, v);
		chk("overflow cleared", v, 16'h0000);
	endtask
	task t_cap;
		wr(tppc_pkg::ADDR_CCC, 16'h0005);
		wr(tppc_pkg::ADDR_PES, 16'h00f0);
		wr(tppc_pkg::ADDR_MODE, 16'h0002);
		a_lvl <= 1'b1;
		b_lvl <= 1'b1;
		repeat (8) @(posedge clock);
		rd(tppc_pkg::ADDR_WIDTH, v);
		rd(tppc_pkg::ADDR_PERIOD, w);
		@(posedge clock);
		a_lvl <= 1'b0;
		repeat (4) @(posedge clock);
		b_lvl <= 1'b0;
		repeat (8) @(posedge clock);
		rd(tppc_pkg::ADDR_WIDTH, c);
		chk("primary width", c - v, 16'h000d);
		rd(tppc_pkg::ADDR_PERIOD, c);
		chk("secondary width", c - w, 16'h0011);
		@(posedge clock);
		a_lvl <= 1'b1;
		@(posedge clock);
		a_lvl <= 1'b0;
		c = 16'h0000;
		cnt(10);
		chk("glitch", c, 16'h0000);
		for (int e = 0; e < 4; e++) begin
			wr(tppc_pkg::ADDR_MODE, 16'h0000);
			wr(tppc_pkg::ADDR_PES, {10'h000, e[1:0], 4'h0});
			wr(tppc_pkg::ADDR_MODE, 16'h0002);
			a_lvl <= 1'b1;
			c = 16'h0000;
			cnt(8);
			@(posedge clock);
			a_lvl <= 1'b0;
			cnt(12);
			chk("edges", c, e == 3 ? 16'h0002 : (e == 2 ? 16'h0000 : 16'h0001));
		end
	endtask
	task t_restart;
		wr(tppc_pkg::ADDR_MODE, 16'h0000);
		wr(tppc_pkg::ADDR_PES, 16'h0030);
		wr(tppc_pkg::ADDR_MODE, 16'h0001);
		a_lvl <= 1'b1;
		repeat (13) @(posedge clock);
		a_lvl <= 1'b0;
		repeat (8) @(posedge clock);
		// the rising edge restarts the count from zero on its own capture cycle,
		// so a pulse of 13 clocks reads back as 12
		rd(tppc_pkg::ADDR_WIDTH, c);
		chk("restart width", c, 16'h000c);
	endtask
	// count clock selections one to three, each over a whole number of its own periods
	task t_div;
		for (int s = 1; s < 4; s++) begin
			wr(tppc_pkg::ADDR_MODE, 16'h0000);
			wr(tppc_pkg::ADDR_PES, {14'h0000, s[1:0]});
			wr(tppc_pkg::ADDR_MODE, 16'h0002);
			repeat (s == 1 ? 39 : 511) @(posedge clock);
			rd(tppc_pkg::ADDR_COUNT, v);
			chk("count clock", v, s == 1 ? 16'h000a : (s == 2 ? 16'h0002 : 16'h0000));
		end
		wr(tppc_pkg::ADDR_MODE, 16'h0000);
	endtask
	task print_verdict;
		if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_ppg();
		t_ovf();
		t_cap();
		t_restart();
		t_div();
		print_verdict();
	end
	// the overflow run dominates; this leaves ample margin past it
	initial begin
		#8000000;
		error_cnt++;
		print_verdict();
	end
endmodule
`default_nettype wire
